// ### hdl/isr_slave_rx.sv
/*
 * Two-wire bus slave receiver with an APB register port.
 * Detects start and stop, matches its own or the general call address,
 * acknowledges per the acknowledge enable bit, posts status codes and
 * stretches the clock after an acknowledge clock while the serial interrupt flag is set.
 * Assumes pad logic resolves the open-drain wires from the enables, and
 * that arbitration-loss pulses come from master logic on pclk.
 */
`timescale 1ns/100ps

// Functional notes
// - Match incoming address against upper seven own-address bits.
// - Own-address bit zero enables answering general call address zero.
// - Rate settings have no effect on slave behaviour.
// - Acknowledge own or general call address only with ack enable set.
// - Enter receiver operation only on own address with write bit or on general call.
// - After own address plus write, set flag and post status.
// - Own address acked gives 0x60; next byte acked per ack enable.
// - After lost arbitration, own address plus write gives 0x68.
// - General call acked gives 0x70, or 0x78 after lost arbitration.
// - Own-address byte acked gives 0x80 with byte in buffer.
// - Own-address byte not acked gives 0x88 and unaddressed state.
// - Begin request pending while unaddressed raises start once bus free.
// - General call byte acked gives 0x90; next ack per enable.
// - Clearing ack enable mid-transfer not-acks the next byte.
// - Ack enable clear ignores addresses but keeps watching the bus.
module isr_slave_rx (
   input  wire logic              pclk,           // APB clock, 250 MHz
   input  wire logic              presetn,        // Asynchronous reset, low
   input  wire logic              psel,           // APB select
   input  wire logic              penable,        // APB access phase
   input  wire logic              pwrite,         // APB direction
   input  wire logic [7:0]        paddr,          // APB byte address
   input  wire logic [31:0]       pwdata,         // APB write data
   output logic      [31:0]       prdata,         // APB read data
   output logic                   pready,         // APB ready
   output logic                   pslverr,        // APB error, unmapped
   input  wire isr_pkg::isr_lines_t line_in,      // Wire levels from pads
   output isr_pkg::isr_lines_t    line_oe,        // High pulls wire low
   input  wire logic              arb_lost,       // Master lost arbitration
   output logic                   start_request,  // Master may send start
   output logic                   irq             // Level interrupt
);

   // ==========================================================
   // Line synchronisers and edge detection
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_prev;
   logic       sda_prev;

   // Two flops per wire; only the second stage feeds logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], line_in.scl};
         sda_sync <= {sda_sync[0], line_in.sda};
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
      end
   end

   wire scl_now  = scl_sync[1];
   wire sda_now  = sda_sync[1];
   wire scl_rise = scl_now & ~scl_prev;
   wire scl_fall = ~scl_now & scl_prev;
   // Start and stop are data edges while the clock stays high.
   wire start_seen = scl_now & scl_prev & sda_prev & ~sda_now;
   wire stop_seen  = scl_now & scl_prev & ~sda_prev & sda_now;

   // ==========================================================
   // Register state
   logic [7:0]  ctrl;
   logic [7:0]  own_addr;
   logic [7:0]  byte_buf;
   logic [7:0]  status;
   logic [15:0] rate_cfg;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_mask;
   logic [31:0] rd_word;

   wire enable   = ctrl[isr_pkg::BIT_ENABLE];
   wire begin_rq = ctrl[isr_pkg::BIT_BEGIN];
   wire si       = ctrl[isr_pkg::BIT_SI];
   wire ack_en   = ctrl[isr_pkg::BIT_ACK_EN];
   wire gc_en    = own_addr[isr_pkg::BIT_GC_EN];

   // ==========================================================
   // APB decode; zero wait states, error on unmapped addresses
   wire setup    = psel & ~penable;
   wire access   = psel & penable;
   wire hit_set  = paddr == isr_pkg::OFF_FLAG_SET;
   wire hit_stat = paddr == isr_pkg::OFF_STATUS;
   wire hit_buf  = paddr == isr_pkg::OFF_BYTE_BUF;
   wire hit_adr  = paddr == isr_pkg::OFF_OWN_ADDR;
   wire hit_clr  = paddr == isr_pkg::OFF_FLAG_CLR;
   wire hit_rate = paddr == isr_pkg::OFF_RATE_CFG;
   wire hit_ist  = paddr == isr_pkg::OFF_IRQ_STATUS;
   wire hit_imsk = paddr == isr_pkg::OFF_IRQ_MASK;
   wire mapped   = hit_set | hit_stat | hit_buf | hit_adr | hit_clr |
                   hit_rate | hit_ist | hit_imsk;
   wire wr       = access & pwrite & mapped;
   wire [7:0] set_mask = (wr & hit_set) ? (pwdata[7:0] & isr_pkg::CTRL_WR_MASK) : 8'h00;
   wire [7:0] clr_mask = (wr & hit_clr) ? (pwdata[7:0] & isr_pkg::CTRL_WR_MASK) : 8'h00;
   wire [2:0] ist_clr  = (wr & hit_ist) ? pwdata[2:0] : 3'h0;

   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // Read selection; the status register is read-only.
   assign rd_word = hit_set  ? {24'h0, ctrl} :
                    hit_clr  ? {24'h0, ctrl} :
                    hit_stat ? {24'h0, status} :
                    hit_buf  ? {24'h0, byte_buf} :
                    hit_adr  ? {24'h0, own_addr} :
                    hit_rate ? {16'h0, rate_cfg} :
                    hit_ist  ? {29'h0, irq_stat} :
                    hit_imsk ? {29'h0, irq_mask} : 32'h0;

   // Read data is captured in the setup cycle so it leaves a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (setup & ~pwrite) begin
         prdata <= rd_word;
      end
   end

   // ==========================================================
   // Receive sequencer state
   localparam isr_pkg::isr_state_t ISR_IDLE = isr_pkg::ISR_IDLE;
   localparam isr_pkg::isr_state_t ISR_ADDR = isr_pkg::ISR_ADDR;
   localparam isr_pkg::isr_state_t ISR_DATA = isr_pkg::ISR_DATA;
   localparam isr_pkg::isr_state_t ISR_ACK  = isr_pkg::ISR_ACK;
   localparam isr_pkg::isr_state_t ISR_HOLD = isr_pkg::ISR_HOLD;
   isr_pkg::isr_state_t state;
   isr_pkg::isr_state_t next_state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic       ack_go;
   logic       addr_phase;
   logic       addressed;
   logic       by_gc;
   logic       lost;
   logic       bus_busy;

   wire byte_done = scl_fall & (bit_cnt == isr_pkg::BITS_PER_BYTE);
   wire own_match = shift[7:1] == own_addr[7:1];
   wire gc_match  = (shift == isr_pkg::GC_ADDRESS) & gc_en;
   // ack enable clear ignores both addresses
   wire take_own  = own_match & ~shift[0] & ack_en;
   wire take_gc   = gc_match & ack_en;
   wire stop_addr = (stop_seen | start_seen) & addressed;

   // rate settings never enter the slave path.
   // Next state of the sequencer; start and stop take priority.
   always_comb begin
      next_state = state;
      case (state)
         ISR_IDLE: next_state = state;
         ISR_ADDR: begin
            if (byte_done) begin
               next_state = (take_own | take_gc) ? ISR_ACK : ISR_IDLE;
            end
         end
         ISR_DATA: begin
            if (byte_done) begin
               next_state = ISR_ACK;
            end
         end
         ISR_ACK: begin
            if (scl_fall) begin
               next_state = ISR_HOLD;
            end
         end
         ISR_HOLD: begin
            if (!si) begin
               next_state = addressed ? ISR_DATA : ISR_IDLE;
            end
         end
         default: next_state = ISR_IDLE;
      endcase
      if (!enable) begin
         next_state = ISR_IDLE;
      end else if (start_seen) begin
         next_state = ISR_ADDR;
      end else if (stop_seen) begin
         next_state = ISR_IDLE;
      end
   end

   // Status code posted at the end of an acknowledge clock.
   wire [7:0] addr_code = by_gc ? (lost ? isr_pkg::ST_GC_LOST : isr_pkg::ST_GC) :
                                  (lost ? isr_pkg::ST_OWN_W_LOST : isr_pkg::ST_OWN_W);
   wire [7:0] data_code = by_gc ? (ack_go ? isr_pkg::ST_GC_DATA_ACK : isr_pkg::ST_GC_DATA_NAK) :
                                  (ack_go ? isr_pkg::ST_OWN_DATA_ACK : isr_pkg::ST_OWN_DATA_NAK);
   wire ack_end   = enable & ~start_seen & ~stop_seen & (state == ISR_ACK) & scl_fall;
   wire stop_post = enable & stop_addr;
   wire hw_si     = ack_end | stop_post;
   wire [2:0] ev  = {stop_post, ack_end & ~addr_phase, ack_end & addr_phase};

   // Sequencer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ISR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Bit counter and shifter advance on each clock rise in the address and data states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt <= 4'h0;
         shift   <= 8'h00;
      end else if (start_seen | (state == ISR_ACK)) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise & ((state == ISR_ADDR) | (state == ISR_DATA))) begin
         bit_cnt <= bit_cnt + 4'h1;
         shift   <= {shift[6:0], sda_now};
      end
   end

   // Address and acknowledge bookkeeping.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_go     <= 1'b0;
         addr_phase <= 1'b0;
         addressed  <= 1'b0;
         by_gc      <= 1'b0;
      end else if (!enable | start_seen | stop_seen) begin
         ack_go     <= 1'b0;
         addr_phase <= 1'b0;
         addressed  <= 1'b0;
         by_gc      <= 1'b0;
      end else if (byte_done & (state == ISR_ADDR)) begin
         ack_go     <= take_own | take_gc;
         addr_phase <= 1'b1;
         addressed  <= take_own | take_gc;
         by_gc      <= take_gc & ~take_own;
      end else if (byte_done & (state == ISR_DATA)) begin
         ack_go     <= ack_en;
         addr_phase <= 1'b0;
      end else if (ack_end & ~addr_phase & ~ack_go) begin
         // a not-acked byte drops the address
         addressed  <= 1'b0;
      end
   end

   // Lost arbitration is remembered until the next address report.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lost <= 1'b0;
      end else if (arb_lost) begin
         lost <= 1'b1;
      end else if (ack_end & addr_phase) begin
         lost <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= isr_pkg::ST_NO_INFO;
      end else if (stop_post) begin
         status <= isr_pkg::ST_STOP_SEEN;
      end else if (ack_end) begin
         status <= addr_phase ? addr_code : data_code;
      end else if (clr_mask[isr_pkg::BIT_SI]) begin
         status <= isr_pkg::ST_NO_INFO;
      end
   end

   // Bus busy tracking feeds the deferred start request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_busy <= 1'b0;
      end else if (start_seen) begin
         bus_busy <= 1'b1;
      end else if (stop_seen) begin
         bus_busy <= 1'b0;
      end
   end

   // start once bus free and unaddressed
   assign start_request = enable & begin_rq & ~bus_busy & ~addressed & (state == ISR_IDLE);

   // ==========================================================
   // Pad drive; the acknowledge decision as it will stand next cycle.
   logic ack_go_next;
   assign ack_go_next = (byte_done & (state == ISR_ADDR)) ? (take_own | take_gc) :
                        (byte_done & (state == ISR_DATA)) ? ack_en : ack_go;

   // Both enables come straight from flops, so the pads never see a glitch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_oe <= '0;
      end else begin
         line_oe.sda <= (next_state == ISR_ACK) & ack_go_next;
         line_oe.scl <= (next_state == ISR_HOLD) & (si | hw_si);
      end
   end

   // ==========================================================
   // Software registers. The hardware flag set wins over a clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= isr_pkg::RST_CTRL;
      end else begin
         ctrl <= ((ctrl | set_mask) & ~clr_mask) | {4'h0, hw_si, 3'h0};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         own_addr <= isr_pkg::RST_OWN_ADDR;
         rate_cfg <= isr_pkg::RST_RATE_CFG;
         irq_mask <= isr_pkg::RST_IRQ;
      end else if (wr) begin
         own_addr <= hit_adr ? pwdata[7:0] : own_addr;
         rate_cfg <= hit_rate ? pwdata[15:0] : rate_cfg;
         irq_mask <= hit_imsk ? pwdata[2:0] : irq_mask;
      end
   end

   // A received byte overrides a software write in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_buf <= isr_pkg::RST_BYTE_BUF;
      end else if (byte_done & (state == ISR_DATA) & enable) begin
         byte_buf <= shift;
      end else if (wr & hit_buf) begin
         byte_buf <= pwdata[7:0];
      end
   end

   // Sticky events: addressed, byte received, stop while addressed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= isr_pkg::RST_IRQ;
      end else begin
         irq_stat <= (irq_stat & ~ist_clr) | ev;
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_addr_needs_ack: assert property ((state == ISR_ADDR) & byte_done & ~ack_en
      |=> state != ISR_ACK) else $error("Address acknowledged with ack enable clear.");
   a_gc_gated: assert property ((state == ISR_ADDR) & byte_done & (shift == 8'h00) & ~gc_en
      |=> state != ISR_ACK) else $error("General call taken while disabled.");
   a_read_refused: assert property ((state == ISR_ADDR) & byte_done & shift[0] & (shift != 8'h00)
      & enable & ~start_seen & ~stop_seen |=> state == ISR_IDLE)
      else $error("Read direction entered receiver operation.");
   a_flag_status: assert property (ack_end & ~si |=> si & (status != isr_pkg::ST_NO_INFO))
      else $error("Flag or status missing after acknowledge clock.");
   a_own_code: assert property (ack_end & addr_phase & ~by_gc & ~lost & ~stop_post
      |=> status == isr_pkg::ST_OWN_W) else $error("Own address status wrong.");
   a_byte_kept: assert property ((state == ISR_DATA) & byte_done & enable & ~start_seen
      & ~stop_seen |=> byte_buf == $past(shift)) else $error("Received byte not buffered.");
   a_nack_drops: assert property (ack_end & ~addr_phase & ~ack_go & ~stop_post
      |=> ~addressed ##1 ~addressed) else $error("Still addressed after not-acked byte.");
   a_ack_follows: assert property ((state == ISR_DATA) & byte_done & ~ack_en & enable
      & ~start_seen & ~stop_seen |=> ##1 ~line_oe.sda) else $error("Data line driven on nack.");
   a_clock_held: assert property ((state == ISR_HOLD) & si & enable & ~start_seen & ~stop_seen
      |=> line_oe.scl) else $error("Clock released while flag set.");
endmodule

// ### common/isr_pkg.sv
/*
 * Shared constants and types for the two-wire slave receiver block:
 * register offsets, control field positions, reset values, status codes
 * and the state encoding of the receive sequencer.
 * Assumes a 32-bit APB register port with word-aligned registers.
 */
package isr_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_FLAG_SET   = 8'h00;
   localparam logic [7:0] OFF_STATUS     = 8'h04;
   localparam logic [7:0] OFF_BYTE_BUF   = 8'h08;
   localparam logic [7:0] OFF_OWN_ADDR   = 8'h0C;
   localparam logic [7:0] OFF_FLAG_CLR   = 8'h10;
   localparam logic [7:0] OFF_RATE_CFG   = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h1C;

   // ==========================================================
   // Control field positions in the flag set register; general call enable is own-address bit zero
   localparam int BIT_ENABLE = 6;
   localparam int BIT_BEGIN  = 5;
   localparam int BIT_HALT   = 4;
   localparam int BIT_SI     = 3;
   localparam int BIT_ACK_EN = 2;
   localparam int BIT_GC_EN  = 0;
   localparam logic [7:0] CTRL_WR_MASK = 8'h7C;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  RST_CTRL     = 8'h00;
   localparam logic [7:0]  RST_OWN_ADDR = 8'h00;
   localparam logic [7:0]  RST_BYTE_BUF = 8'h00;
   localparam logic [15:0] RST_RATE_CFG = 16'h0000;
   localparam logic [2:0]  RST_IRQ      = 3'h0;

   // ==========================================================
   // Status codes, general call address and bits per byte
   localparam logic [7:0] ST_OWN_W        = 8'h60;
   localparam logic [7:0] ST_OWN_W_LOST   = 8'h68;
   localparam logic [7:0] ST_GC           = 8'h70;
   localparam logic [7:0] ST_GC_LOST      = 8'h78;
   localparam logic [7:0] ST_OWN_DATA_ACK = 8'h80;
   localparam logic [7:0] ST_OWN_DATA_NAK = 8'h88;
   localparam logic [7:0] ST_GC_DATA_ACK  = 8'h90;
   localparam logic [7:0] ST_GC_DATA_NAK  = 8'h98;
   localparam logic [7:0] ST_STOP_SEEN    = 8'hA0;
   localparam logic [7:0] ST_NO_INFO      = 8'hF8;
   localparam logic [7:0] GC_ADDRESS      = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

   // ==========================================================
   // Types
   typedef enum logic [4:0] {
      ISR_IDLE = 5'h01,
      ISR_ADDR = 5'h02,
      ISR_DATA = 5'h04,
      ISR_ACK  = 5'h08,
      ISR_HOLD = 5'h10
   } isr_state_t;

   // Open-drain line pair as seen by the pads.
   typedef struct packed {
      logic scl;
      logic sda;
   } isr_lines_t;

endpackage

// ### test/isr_master_model.sv
/* Behavioural two-wire bus master transmitter for the slave receiver bench.
   Assumes the bench resolves each wire from every open-drain enable. */
`timescale 1ns/100ps
module isr_master_model (
   input  wire logic pclk,    // Bench clock
   input  wire logic scl,     // Resolved clock wire
   input  wire logic sda,     // Resolved data wire
   output logic      scl_oe,  // High pulls the clock wire low
   output logic      sda_oe,  // High pulls the data wire low
   output logic      ack_stb, // One-cycle pulse per ack slot
   output logic      ack_bit  // Data wire level seen in the ack slot
);
   // ==========================================================
   // Idle bus: both wires released.
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      ack_stb = 1'b0;
      ack_bit = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // The slave may stretch the low phase, so wait until the wire is high.
   task automatic rise_scl();
      scl_oe <= 1'b0;
      @(posedge pclk);
      while (scl !== 1'b1) @(posedge pclk);
   endtask
   task automatic start_cond();
      @(posedge pclk);
      sda_oe <= 1'b1;
      tick(20);
      scl_oe <= 1'b1;
      tick(10);
   endtask
   // Bits go out MSB first, data changing only while the clock is low.
   task automatic send_byte(input logic [7:0] b);
      @(posedge pclk);
      for (int i = 7; i >= 0; i--) begin
         sda_oe <= ~b[i];
         tick(10);
         rise_scl();
         tick(20);
         scl_oe <= 1'b1;
         tick(10);
      end
      sda_oe <= 1'b0;
      tick(10);
      rise_scl();
      tick(10);
      ack_bit <= sda;
      ack_stb <= 1'b1;
      tick(1);
      ack_stb <= 1'b0;
      tick(9);
      scl_oe <= 1'b1;
      tick(20);
   endtask
   task automatic stop_cond();
      @(posedge pclk);
      sda_oe <= 1'b1;
      tick(10);
      rise_scl();
      tick(20);
      sda_oe <= 1'b0;
      tick(20);
   endtask
endmodule

// ### test/test_isr_slave_rx.sv
/* Self-checking bench for isr_slave_rx: APB driver, bus master model and a
   watcher comparing read data and ack slots against queued notes.
   Assumes pull-ups on both wires, resolved here from all enables. */
`timescale 1ns/100ps
module test_isr_slave_rx;
   logic                pclk = 1'b0;
   logic                presetn = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic                arb_lost = 1'b0;
   logic [7:0]          paddr = 8'h00;
   logic [31:0]         pwdata = 32'h0;
   logic [31:0]         prdata;
   logic                pready, pslverr, start_request, irq;
   logic                scl_oe, sda_oe, ack_stb, ack_bit;
   isr_pkg::isr_lines_t line_in, line_oe;
   logic [31:0]         rq[$];
   logic                aq[$];
   int                  err_count = 0;
   int                  checks_done = 0;
   int                  cycles = 0;
   integer              seed = 32'h3F6BA8BB;
   logic [6:0]          own = 7'h3A;
   logic [7:0]          d;
   // ==========================================================
   // Clock, wires and instances
   always #2 pclk = ~pclk;
   // A wire is low while any party pulls it, else the pull-up wins.
   assign line_in.scl = ~(line_oe.scl | scl_oe);
   assign line_in.sda = ~(line_oe.sda | sda_oe);
   isr_slave_rx dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .line_in, .line_oe, .arb_lost, .start_request, .irq);
   isr_master_model m (.pclk, .scl(line_in.scl), .sda(line_in.sda), .scl_oe, .sda_oe,
      .ack_stb, .ack_bit);
   // ==========================================================
   // Tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (err_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // A read notes its expected data; the task ends off the edge so flags settle.
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] v);
      @(posedge pclk);
      if (!w) rq.push_back(v);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? v : 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic st(input logic [7:0] c);
      apb(isr_pkg::OFF_STATUS, 1'b0, {24'h0, c});
   endtask
   task automatic clr();
      apb(isr_pkg::OFF_FLAG_CLR, 1'b1, 32'h8);
   endtask
   task automatic xfer(input logic [7:0] b, input logic nack);
      aq.push_back(nack);
      m.send_byte(b);
   endtask
   // ==========================================================
   // Watcher and timeout
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         check("pslverr", {31'h0, pslverr}, {31'h0, paddr > 8'h1C});
         if (!pwrite)
            check("prdata", prdata, rq.pop_front());
      end
      if (ack_stb)
         check("ack", {31'h0, ack_bit}, {31'h0, aq.pop_front()});
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         err_count++;
         wrap_up();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      st(isr_pkg::ST_NO_INFO);
      apb(isr_pkg::OFF_OWN_ADDR, 1'b0, 32'h0);
      apb(8'h20, 1'b0, 32'h0);
      apb(isr_pkg::OFF_RATE_CFG, 1'b1, $random(seed));
      apb(isr_pkg::OFF_OWN_ADDR, 1'b1, {24'h0, own, 1'b1});
      apb(isr_pkg::OFF_IRQ_MASK, 1'b1, 32'h7);
      apb(isr_pkg::OFF_FLAG_SET, 1'b1, 32'h44);
      apb(isr_pkg::OFF_FLAG_SET, 1'b0, 32'h44);
      m.start_cond();
      xfer({own, 1'b0}, 1'b0);
      st(isr_pkg::ST_OWN_W);
      check("scl_hold", {31'h0, line_oe.scl}, 32'h1);
      apb(isr_pkg::OFF_IRQ_STATUS, 1'b0, 32'h1);
      check("irq", {31'h0, irq}, 32'h1);
      apb(isr_pkg::OFF_IRQ_MASK, 1'b1, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      apb(isr_pkg::OFF_IRQ_MASK, 1'b1, 32'h7);
      apb(isr_pkg::OFF_IRQ_STATUS, 1'b1, 32'h7);
      check("irq", {31'h0, irq}, 32'h0);
      clr();
      d = $random(seed);
      xfer(d, 1'b0);
      st(isr_pkg::ST_OWN_DATA_ACK);
      apb(isr_pkg::OFF_BYTE_BUF, 1'b0, {24'h0, d});
      apb(isr_pkg::OFF_FLAG_CLR, 1'b1, 32'h4);
      clr();
      xfer(~d, 1'b1);
      st(isr_pkg::ST_OWN_DATA_NAK);
      apb(isr_pkg::OFF_FLAG_SET, 1'b1, 32'h20);
      clr();
      check("start_request", {31'h0, start_request}, 32'h0);
      m.stop_cond();
      @(negedge pclk);
      check("start_request", {31'h0, start_request}, 32'h1);
      apb(isr_pkg::OFF_FLAG_CLR, 1'b1, 32'h20);
      st(isr_pkg::ST_NO_INFO);
      m.start_cond();
      xfer({own, 1'b0}, 1'b1);
      m.stop_cond();
      apb(isr_pkg::OFF_FLAG_SET, 1'b1, 32'h4);
      // Own and general call, each plain and after lost arbitration.
      for (int k = 0; k < 4; k++) begin
         @(posedge pclk);
         arb_lost <= k[1];
         @(posedge pclk);
         arb_lost <= 1'b0;
         m.start_cond();
         xfer(k[0] ? isr_pkg::GC_ADDRESS : {own, 1'b0}, 1'b0);
         st(k[1] ? (k[0] ? isr_pkg::ST_GC_LOST : isr_pkg::ST_OWN_W_LOST)
                 : (k[0] ? isr_pkg::ST_GC : isr_pkg::ST_OWN_W));
         clr();
         d = $random(seed);
         xfer(d, 1'b0);
         st(k[0] ? isr_pkg::ST_GC_DATA_ACK : isr_pkg::ST_OWN_DATA_ACK);
         apb(isr_pkg::OFF_BYTE_BUF, 1'b0, {24'h0, d});
         clr();
         m.stop_cond();
         st(isr_pkg::ST_STOP_SEEN);
         clr();
      end
      // Read bit, foreign address and general call with it disabled.
      apb(isr_pkg::OFF_OWN_ADDR, 1'b1, {24'h0, own, 1'b0});
      for (int k = 0; k < 3; k++) begin
         d = k == 0 ? {own, 1'b1} : k == 1 ? {~own, 1'b0} : isr_pkg::GC_ADDRESS;
         m.start_cond();
         xfer(d, 1'b1);
         m.stop_cond();
      end
      st(isr_pkg::ST_NO_INFO);
      wrap_up();
   end
endmodule
